// file: rtl/exec_unit.v
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "exec_unit_consts.vh"

// Contract
// - Clear-register op writes zero to the register, sets zero flag, one cycle.
// - Access bit zero picks access bank; one uses bank select register.
// - Access bit zero, extended set on, f up to 5Fh: indexed offset.
// - Call pushes own address plus four, loads target, second cycle idle.
// - Call with fast bit copies W, flags, bank select into shadows.
module exec_unit (
   input  wire        clk,
   input  wire        nrst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [11:0] dmem_addr,
   output reg  [7:0]  dmem_wdata,
   input  wire [7:0]  dmem_rdata,
   output reg         dmem_re,
   output reg         dmem_we,
   output reg         stack_push,
   output reg  [20:0] stack_top
);

   localparam S_IDLE  = 4'b0001;
   localparam S_WORD2 = 4'b0010;
   localparam S_EXEC  = 4'b0100;
   localparam S_SPARE = 4'b1000;

   // ------------------------------------------------------------
   // Quarter-cycle phase ring, one enable per phase
   // ------------------------------------------------------------
   reg  [3:0]  ph_q;
   wire        q1 = ph_q[0];
   wire        q2 = ph_q[1];
   wire        q3 = ph_q[2];
   wire        q4 = ph_q[3];

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph_q <= `RST_PHASE;
      end else begin
         ph_q <= {ph_q[2:0], ph_q[3]};
      end
   end

   reg  [3:0]  state_q;
   reg         started_q;
   reg  [15:0] instr_q;
   reg  [11:0] word2_q;
   reg         ext_en_q;
   reg  [7:0]  work_q;
   reg  [4:0]  flags_q;
   reg  [3:0]  bank_q;
   reg  [20:0] pc_q;
   reg  [11:0] index_q;
   reg  [7:0]  working_shadow;
   reg  [4:0]  flags_shadow;
   reg  [3:0]  bank_select_shadow;
   reg  [7:0]  watchdog_counter;
   reg  [7:0]  wdog_post_q;
   reg         timeout_flag;
   reg         powerdown_flag;
   reg  [7:0]  res_q;
   reg         unknown_q;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire        call_op            = instr_q[15:9] == `OPC_CALL;
   wire        clear_register_op  = instr_q[15:9] == `OPC_CLEAR_REGISTER_OP;
   wire        invert_register_op = instr_q[15:10] == `OPC_INVERT_REGISTER_OP;
   wire        watchdog_reset_op  = instr_q == `OPC_WATCHDOG_RESET_OP;
   wire        file_op  = clear_register_op | invert_register_op;
   wire        dest_bit = instr_q[9];
   wire        fast_bit = instr_q[8];
   wire [11:0] eff_addr;

   operand_addr operand_addr_i (
      .file_sel        (instr_q[7:0]),
      .access_bit      (instr_q[8]),
      .ext_en          (ext_en_q),
      .bank_select_reg (bank_q),
      .index_base      (index_q),
      .eff_addr        (eff_addr)
   );

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire        acc    = psel & penable & ~pready;
   wire        busy   = state_q == S_EXEC || state_q == S_SPARE;
   // Writes wait while an instruction runs; avoids racing the core
   wire        wr_ok  = ~busy;
   wire        hit    = paddr == `OFF_INSTR  || paddr == `OFF_CTRL  ||
                        paddr == `OFF_WORK   || paddr == `OFF_FLAGS ||
                        paddr == `OFF_BANK   || paddr == `OFF_PC    ||
                        paddr == `OFF_STACK  || paddr == `OFF_SHADOW ||
                        paddr == `OFF_WDOG   || paddr == `OFF_INDEX;
   wire        do_wr  = acc & pwrite & wr_ok & hit;
   reg  [31:0] rd_mux;

   always @* begin
      case (paddr)
         `OFF_INSTR:  rd_mux = {13'h0, unknown_q, busy,
                                state_q == S_WORD2, instr_q};
         `OFF_CTRL:   rd_mux = {31'h0, ext_en_q};
         `OFF_WORK:   rd_mux = {24'h0, work_q};
         `OFF_FLAGS:  rd_mux = {27'h0, flags_q};
         `OFF_BANK:   rd_mux = {28'h0, bank_q};
         `OFF_PC:     rd_mux = {11'h0, pc_q};
         `OFF_STACK:  rd_mux = {11'h0, stack_top};
         `OFF_SHADOW: rd_mux = {15'h0, bank_select_shadow, flags_shadow,
                                working_shadow};
         `OFF_WDOG:   rd_mux = {14'h0, timeout_flag, powerdown_flag,
                                wdog_post_q, watchdog_counter};
         `OFF_INDEX:  rd_mux = {20'h0, index_q};
         default:     rd_mux = 32'h0;
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= acc & (~pwrite | wr_ok | ~hit);
         pslverr <= acc & ~hit;
         prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   // ------------------------------------------------------------
   // Sequencer and core registers
   // ------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q            <= S_IDLE;
         started_q          <= 1'b0;
         instr_q            <= `RST_INSTR;
         word2_q            <= 12'h000;
         ext_en_q           <= 1'b0;
         work_q             <= `RST_BYTE;
         flags_q            <= `RST_FLAGS;
         bank_q             <= `RST_BANK;
         pc_q               <= `RST_PC;
         index_q            <= `RST_INDEX;
         working_shadow     <= `RST_BYTE;
         flags_shadow       <= `RST_FLAGS;
         bank_select_shadow <= `RST_BANK;
         watchdog_counter   <= `RST_BYTE;
         wdog_post_q        <= `RST_BYTE;
         timeout_flag       <= 1'b1;
         powerdown_flag     <= 1'b1;
         res_q              <= `RST_BYTE;
         unknown_q          <= 1'b0;
         dmem_addr          <= 12'h000;
         dmem_wdata         <= `RST_BYTE;
         dmem_re            <= 1'b0;
         dmem_we            <= 1'b0;
         stack_push         <= 1'b0;
         stack_top          <= `RST_PC;
      end else begin
         dmem_re    <= 1'b0;
         dmem_we    <= 1'b0;
         stack_push <= 1'b0;

         // Free-running watchdog, one tick per instruction cycle
         if (q4) begin
            watchdog_counter <= watchdog_counter + 8'h01;
            if (&watchdog_counter) begin
               wdog_post_q <= wdog_post_q + 8'h01;
               if (&wdog_post_q) begin
                  timeout_flag <= 1'b0;
               end
            end
         end

         if (do_wr) begin
            case (paddr)
               `OFF_INSTR: begin
                  if (state_q == S_WORD2) begin
                     word2_q <= pwdata[11:0];
                     state_q <= S_EXEC;
                  end else begin
                     instr_q   <= pwdata[15:0];
                     unknown_q <= 1'b0;
                     state_q   <= (pwdata[15:9] == `OPC_CALL) ?
                                  S_WORD2 : S_EXEC;
                  end
               end
               `OFF_CTRL:  ext_en_q <= pwdata[0];
               `OFF_WORK:  work_q   <= pwdata[7:0];
               `OFF_FLAGS: flags_q  <= pwdata[4:0];
               `OFF_BANK:  bank_q   <= pwdata[3:0];
               `OFF_PC:    pc_q     <= pwdata[20:0];
               `OFF_INDEX: index_q  <= pwdata[11:0];
               default: begin
               end
            endcase
         end

         case (state_q)
            S_EXEC: begin
               if (q1) begin
                  started_q <= 1'b1;
               end
               if (q2 && started_q && file_op) begin
                  dmem_addr <= eff_addr;
                  dmem_re   <= invert_register_op;
               end
               if (q3 && started_q) begin
                  if (clear_register_op) begin
                     res_q             <= `RST_BYTE;
                     flags_q[`FLAG_Z]  <= 1'b1;
                  end
                  // Memory answers while the read strobe stands
                  if (invert_register_op) begin
                     res_q             <= ~dmem_rdata;
                     flags_q[`FLAG_N]  <= ~dmem_rdata[7];
                     flags_q[`FLAG_Z]  <= &dmem_rdata;
                  end
                  if (watchdog_reset_op) begin
                     watchdog_counter  <= `RST_BYTE;
                     wdog_post_q       <= `RST_BYTE;
                     timeout_flag      <= 1'b1;
                     powerdown_flag    <= 1'b1;
                  end
                  if (call_op) begin
                     stack_top  <= pc_q + `RET_STEP;
                     stack_push <= 1'b1;
                     if (fast_bit) begin
                        working_shadow     <= work_q;
                        flags_shadow       <= flags_q;
                        bank_select_shadow <= bank_q;
                     end
                  end
                  unknown_q <= ~(file_op | watchdog_reset_op | call_op);
               end
               if (q4 && started_q) begin
                  started_q <= 1'b0;
                  if (clear_register_op ||
                      (invert_register_op && dest_bit)) begin
                     dmem_wdata <= res_q;
                     dmem_we    <= 1'b1;
                  end
                  if (invert_register_op && !dest_bit) begin
                     work_q <= res_q;
                  end
                  if (call_op) begin
                     pc_q    <= {word2_q, instr_q[7:0], 1'b0};
                     state_q <= S_SPARE;
                  end else begin
                     pc_q    <= pc_q + `PC_STEP;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_SPARE: begin
               // Idle second cycle of the call, no side effects
               if (q1) begin
                  started_q <= 1'b1;
               end
               if (q4 && started_q) begin
                  started_q <= 1'b0;
                  state_q   <= S_IDLE;
               end
            end
            S_IDLE, S_WORD2: begin
               started_q <= 1'b0;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// file: rtl/exec_unit_consts.vh
`ifndef EXEC_UNIT_CONSTS_VH
`define EXEC_UNIT_CONSTS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFF_INSTR       8'h00
`define OFF_CTRL        8'h04
`define OFF_WORK        8'h08
`define OFF_FLAGS       8'h0C
`define OFF_BANK        8'h10
`define OFF_PC          8'h14
`define OFF_STACK       8'h18
`define OFF_SHADOW      8'h1C
`define OFF_WDOG        8'h20
`define OFF_INDEX       8'h24

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define OPC_CALL        7'h76
`define OPC_CLEAR_REGISTER_OP        7'h35
`define OPC_INVERT_REGISTER_OP        6'h07
`define OPC_WATCHDOG_RESET_OP      16'h0004

// ---------------------------------------------------------------
// Flag positions and addressing
// ---------------------------------------------------------------
`define FLAG_N          4
`define FLAG_Z          2
`define ILO_LIMIT       8'h5F
`define ACC_SPLIT       8'h80
`define ACC_LOW_BANK    4'h0
`define ACC_HIGH_BANK   4'hF
`define RET_STEP        21'h000004
`define PC_STEP         21'h000002

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_PHASE       4'h1
`define RST_BYTE        8'h00
`define RST_FLAGS       5'h00
`define RST_BANK        4'h0
`define RST_PC          21'h000000
`define RST_INDEX       12'h000
`define RST_INSTR       16'h0000

`endif

// file: rtl/operand_addr.v
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Effective data address of a byte-oriented file operand
// ---------------------------------------------------------------
module operand_addr (
   input  wire [7:0]  file_sel,
   input  wire        access_bit,
   input  wire        ext_en,
   input  wire [3:0]  bank_select_reg,
   input  wire [11:0] index_base,
   output reg  [11:0] eff_addr
);

   always @* begin
      if (access_bit) begin
         eff_addr = {bank_select_reg, file_sel};
      end else if (ext_en && file_sel <= `ILO_LIMIT) begin
         eff_addr = index_base + {4'h0, file_sel};
      end else if (file_sel < `ACC_SPLIT) begin
         eff_addr = {`ACC_LOW_BANK, file_sel};
      end else begin
         eff_addr = {`ACC_HIGH_BANK, file_sel};
      end
   end

endmodule

// file: sim/exec_unit_properties.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Port-level checker
// ---------------------------------------------------------------
module exec_unit_checker (
   input wire        clk,
   input wire        nrst,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   input wire [31:0] prdata,
   input wire [11:0] dmem_addr,
   input wire        dmem_re,
   input wire        dmem_we,
   input wire        stack_push,
   input wire [20:0] stack_top
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_READY_REQ: assert property (pready |-> psel && penable)
      else $error("ready without an access phase");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside the ready cycle");
   AST_WE_PULSE: assert property (dmem_we |=> !dmem_we)
      else $error("write strobe longer than one cycle");
   AST_WE_ADDR: assert property (dmem_we |-> $stable(dmem_addr))
      else $error("address moved under the write strobe");
   AST_RE_PULSE: assert property (dmem_re |=> !dmem_re)
      else $error("read strobe longer than one cycle");
   AST_RE_WE: assert property (!(dmem_re && dmem_we))
      else $error("read and write strobe together");
   AST_PUSH_PULSE: assert property (stack_push |=> !stack_push)
      else $error("push longer than one cycle");
   AST_PUSH_EVEN: assert property (stack_push |-> !stack_top[0])
      else $error("odd return address pushed");
   AST_TOP_STANDS: assert property
      ($changed(stack_top) |-> stack_push || $past(stack_push))
      else $error("stack top moved without a push");
endmodule

bind exec_unit exec_unit_checker checker_i (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we),
   .stack_push(stack_push), .stack_top(stack_top));

// file: sim/exec_unit_bench.sv
`timescale 1ns/1ps
`include "exec_unit_consts.vh"

module exec_unit_bench;
   reg         clk, nrst, psel, penable, pwrite;
   reg  [7:0]  paddr, dmem_rdata, we_data;
   reg  [31:0] pwdata, rd;
   reg  [11:0] we_addr;
   reg         er;
   wire [31:0] prdata;
   wire        pready, pslverr, dmem_re, dmem_we, stack_push;
   wire [11:0] dmem_addr;
   wire [7:0]  dmem_wdata;
   wire [20:0] stack_top;
   integer     mismatches, n_compared, we_cnt, push_cnt;

   exec_unit exec_unit_i (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_re(dmem_re),
      .dmem_we(dmem_we), .dmem_rdata(dmem_rdata), .stack_push(stack_push),
      .stack_top(stack_top));

   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Strobe monitor
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (dmem_we === 1'b1) begin
         we_addr <= dmem_addr;
         we_data <= dmem_wdata;
         we_cnt  <= we_cnt + 1;
      end
      if (stack_push === 1'b1) push_cnt <= push_cnt + 1;
   end

   task conclude;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   task check(input [63:0] seen, input [63:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // Entered just after a rising edge, returns just after one
   task apb(input [7:0] a, input w, input [31:0] d,
            output [31:0] r, output e);
      integer n;
      begin
         psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         n = 0;
         @(posedge clk);
         while (pready !== 1'b1 && n < 200) begin
            @(posedge clk);
            n = n + 1;
         end
         r = prdata;
         e = pslverr;
         psel <= 1'b0; penable <= 1'b0;
         @(posedge clk);
         if (n >= 200) begin
            mismatches = mismatches + 1;
            conclude;
         end
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      apb(a, 1'b1, d, rd, er);
   endtask

   task rdchk(input [7:0] a, input [31:0] exp);
      begin
         apb(a, 1'b0, 32'h0, rd, er);
         check(rd, exp);
      end
   endtask

   // Busy flag in the instruction register tells when it has retired
   task exec(input [15:0] op);
      integer n;
      begin
         wr(`OFF_INSTR, {16'h0, op});
         n = 0;
         rd = 32'h00020000;
         while (rd[17] !== 1'b0 && n < 30) begin
            apb(`OFF_INSTR, 1'b0, 32'h0, rd, er);
            n = n + 1;
         end
         check({31'h0, rd[17]}, 32'h0);
      end
   endtask

   task t_reset;
      begin
         rdchk(`OFF_WORK, 32'h0);
         rdchk(`OFF_FLAGS, 32'h0);
         rdchk(`OFF_PC, 32'h0);
         apb(`OFF_WDOG, 1'b0, 32'h0, rd, er);
         check(rd[17:16], 2'h3);
         apb(8'h28, 1'b0, 32'h0, rd, er);
         check({er, rd}, {1'b1, 32'h0});
      end
   endtask

   task t_clear_register_op;
      begin
         wr(`OFF_BANK, 32'h3);
         wr(`OFF_FLAGS, 32'h0);
         exec({`OPC_CLEAR_REGISTER_OP, 1'b1, 8'h42});
         check({we_cnt, we_addr, we_data}, {32'd1, 12'h342, 8'h00});
         rdchk(`OFF_FLAGS, 32'h4);
         exec({`OPC_CLEAR_REGISTER_OP, 1'b0, 8'h90});
         check({we_cnt, we_addr}, {32'd2, 12'hF90});
      end
   endtask

   task t_indexed;
      begin
         wr(`OFF_CTRL, 32'h1);
         wr(`OFF_INDEX, 32'h200);
         exec({`OPC_CLEAR_REGISTER_OP, 1'b0, 8'h5F});
         check({we_cnt, we_addr}, {32'd3, 12'h25F});
         exec({`OPC_CLEAR_REGISTER_OP, 1'b0, 8'h60});
         check({we_cnt, we_addr}, {32'd4, 12'h060});
         exec({`OPC_CLEAR_REGISTER_OP, 1'b1, 8'h05});
         check({we_cnt, we_addr}, {32'd5, 12'h305});
         wr(`OFF_CTRL, 32'h0);
      end
   endtask

   task t_invert_register_op;
      begin
         dmem_rdata <= 8'h13;
         exec({`OPC_INVERT_REGISTER_OP, 1'b0, 1'b1, 8'h10});
         rdchk(`OFF_WORK, 32'hEC);
         rdchk(`OFF_FLAGS, 32'h10);
         check(we_cnt, 32'd5);
         dmem_rdata <= 8'hFF;
         exec({`OPC_INVERT_REGISTER_OP, 1'b1, 1'b1, 8'h21});
         check({we_cnt, we_addr, we_data}, {32'd6, 12'h321, 8'h00});
         rdchk(`OFF_FLAGS, 32'h04);
         rdchk(`OFF_WORK, 32'hEC);
      end
   endtask

   task t_wdog;
      begin
         exec(`OPC_WATCHDOG_RESET_OP);
         apb(`OFF_WDOG, 1'b0, 32'h0, rd, er);
         check({rd[17:8], 1'b0}, {2'h3, 8'h00, 1'b0});
         check({31'h0, rd[7:0] < 8'h4}, 32'h1);
      end
   endtask

   task t_call;
      begin
         wr(`OFF_WORK, 32'h5A);
         wr(`OFF_FLAGS, 32'h14);
         wr(`OFF_PC, 32'h100);
         wr(`OFF_INSTR, {16'h0, `OPC_CALL, 1'b1, 8'h34});
         exec({4'hF, 12'h012});
         check({push_cnt, 11'h0, stack_top}, {32'd1, 32'h104});
         rdchk(`OFF_PC, 32'h2468);
         rdchk(`OFF_STACK, 32'h104);
         rdchk(`OFF_SHADOW, {15'h0, 4'h3, 5'h14, 8'h5A});
         wr(`OFF_WORK, 32'h77);
         wr(`OFF_INSTR, {16'h0, `OPC_CALL, 1'b0, 8'h00});
         exec({4'hF, 12'h000});
         rdchk(`OFF_SHADOW, {15'h0, 4'h3, 5'h14, 8'h5A});
         rdchk(`OFF_STACK, 32'h246C);
         wr(`OFF_STACK, 32'hFFFF);
         rdchk(`OFF_STACK, 32'h246C);
      end
   endtask

   initial begin
      nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
      pwdata = 32'h0; dmem_rdata = 8'h00; we_cnt = 0; push_cnt = 0;
      mismatches = 0; n_compared = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset;
      t_clear_register_op;
      t_indexed;
      t_invert_register_op;
      t_wdog;
      t_call;
      conclude;
   end
endmodule
